// [hw/encoder_fast_counter_two_pkg.sv]
package encoder_fast_counter_two_pkg;

  // register offsets, one 16-bit register each
  localparam logic [4:0] OFS_ONE_SPEED_PERIOD = 5'h00;
  localparam logic [4:0] OFS_ONE_ERROR_ENABLE = 5'h01;
  localparam logic [4:0] OFS_COUNT_MODE = 5'h02;
  localparam logic [4:0] OFS_INDEX_ACTION = 5'h03;
  localparam logic [4:0] OFS_PRESET_LOAD = 5'h04;
  localparam logic [4:0] OFS_PRESET_LOW = 5'h05;
  localparam logic [4:0] OFS_PRESET_HIGH = 5'h06;
  localparam logic [4:0] OFS_PULSES_PER_REV = 5'h07;
  localparam logic [4:0] OFS_SPEED_FILTER_HZ = 5'h08;
  localparam logic [4:0] OFS_TWO_SPEED_PERIOD = 5'h09;
  localparam logic [4:0] OFS_TWO_ERROR_ENABLE = 5'h0a;
  localparam logic [4:0] OFS_CAPTURE_LOW = 5'h0b;
  localparam logic [4:0] OFS_CAPTURE_HIGH = 5'h0c;
  localparam logic [4:0] OFS_COUNT_LOW = 5'h0d;
  localparam logic [4:0] OFS_COUNT_HIGH = 5'h0e;
  localparam logic [4:0] OFS_REV_FRACTION = 5'h0f;
  localparam logic [4:0] OFS_REV_COUNT = 5'h10;
  localparam logic [4:0] OFS_SPEED_LOW = 5'h11;
  localparam logic [4:0] OFS_SPEED_HIGH = 5'h12;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h13;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h14;

  // values after reset
  localparam logic [15:0] RST_SPEED_PERIOD = 16'h000a;
  localparam logic [15:0] RST_PULSES_PER_REV = 16'h0400;
  localparam logic [15:0] RST_SPEED_FILTER_HZ = 16'h01f4;

  // interrupt status bit positions
  localparam int IRQ_INDEX = 0;
  localparam int IRQ_PRESET = 1;
  localparam int IRQ_ONE_LOSS = 2;
  localparam int IRQ_TWO_LOSS = 3;
  localparam int IRQ_SPEED = 4;
  localparam int IRQ_BITS = 5;

  // timing: speed period counts in ticks of 0.1 ms
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_NS = 100_000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int LOSS_TIME_NS = 10_000;
  localparam int LOSS_CYCLES = (CLK_HZ / 1_000_000) * LOSS_TIME_NS / 1000;

  // filter gain per hertz in q16: 2*pi*tick*65536
  localparam logic [16:0] FILTER_GAIN_Q16 = 17'h00029;
  localparam logic [16:0] FILTER_ONE_Q16 = 17'h10000;

  typedef enum logic [1:0] {MODE_OFF, MODE_QUAD, MODE_PULSE_DIR, MODE_UP_DOWN} count_mode_t;

  typedef enum logic [2:0] {
    IDX_NONE, IDX_CLEAR, IDX_CAP_TWO_RISE, IDX_CAP_TWO_FALL, IDX_CAP_ONE_RISE, IDX_CAP_ONE_FALL
  } index_action_t;

  typedef enum logic [1:0] {ERR_OFF, ERR_ALARM, ERR_FAULT} error_mode_t;

  typedef struct packed {
    logic channel_a;
    logic channel_a_n;
    logic channel_b;
    logic channel_b_n;
    logic index;
    logic index_n;
  } enc_inputs_t;

endpackage

// [hw/step_decoder.sv]
`timescale 1ns/1ps
module step_decoder
  import encoder_fast_counter_two_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // mode and channels
  input count_mode_t mode,
  input wire logic chan_a,
  input wire logic chan_b,
  // one-cycle steps
  output logic step_up,
  output logic step_down
);
  logic prev_a;
  logic prev_b;
  logic quad_up;
  logic quad_down;

  // a leading b counts up; a double change is a lost state and is ignored
  assign quad_up = (chan_a ^ prev_b) & ~(chan_b ^ prev_a);
  assign quad_down = (chan_b ^ prev_a) & ~(chan_a ^ prev_b);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end
    else
    begin
      prev_a <= chan_a;
      prev_b <= chan_b;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      step_up <= 1'b0;
      step_down <= 1'b0;
    end
    else
    begin
      case (mode)
        MODE_QUAD:
        begin
          step_up <= quad_up;
          step_down <= quad_down;
        end
        MODE_PULSE_DIR:
        begin
          step_up <= chan_a & ~prev_a & chan_b;
          step_down <= chan_a & ~prev_a & ~chan_b;
        end
        MODE_UP_DOWN:
        begin
          // simultaneous pulses cancel
          step_up <= chan_a & ~prev_a & ~(chan_b & ~prev_b);
          step_down <= chan_b & ~prev_b & ~(chan_a & ~prev_a);
        end
        default:
        begin
          step_up <= 1'b0;
          step_down <= 1'b0;
        end
      endcase
    end
  end
endmodule // step_decoder

// [hw/speed_lowpass.sv]
`timescale 1ns/1ps
module speed_lowpass
  import encoder_fast_counter_two_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // raw estimate, sampled once per tick
  input wire logic sample,
  input wire logic signed [31:0] raw,
  input wire logic [15:0] cutoff_hz,
  // smoothed estimate
  output logic signed [31:0] filtered
);
  logic [16:0] alpha;
  logic [32:0] scaled;
  logic signed [32:0] diff;
  logic signed [50:0] prod;

  // above about 1.6 khz the gain saturates and the stage passes raw speed
  assign scaled = {17'h00000, (cutoff_hz == 16'h0000) ? 16'h0001 : cutoff_hz} * 
                  {16'h0000, FILTER_GAIN_Q16};
  assign alpha = (scaled > {16'h0000, FILTER_ONE_Q16}) ? FILTER_ONE_Q16 : scaled[16:0];
  assign diff = {raw[31], raw} - {filtered[31], filtered};
  assign prod = diff * $signed({1'b0, alpha});

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      filtered <= 32'sh00000000;
    else if (sample)
      filtered <= filtered + prod[47:16];
  end
endmodule // speed_lowpass

// [hw/encoder_fast_counter_two.sv]
`timescale 1ns/1ps
// Contract
// - counter two count mode is set 0 to 3, zero after reset.
// - modes: off, quadrature, pulse with direction, up on a and down on b.
// - index two edges clear the counter or capture counter two or one.
// - captured values read back through a low and a high result register.
// - only a rising edge of the load bit copies the preset into counter two.
// - preset is built from a low and a high 16-bit half.
// - pulses per revolution, 0 to 65535, 1024 after reset, scales position.
// - speed filter cut-off 1 to 4000 hz, 500 hz after reset; above about 1.6 khz the stage passes raw speed.
// - the speed filter is a first-order low-pass stage.
// - speed is position difference over a 0.1 to 100 ms period, 1 ms default.
// - signal loss on input one gives nothing, an alarm or a fault.
// - input two has its own loss supervision, same coding, zero after reset.
module encoder_fast_counter_two
  import encoder_fast_counter_two_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // encoder inputs
  input encoder_fast_counter_two_pkg::enc_inputs_t enc_one_in,
  input encoder_fast_counter_two_pkg::enc_inputs_t enc_two_in,
  input wire logic [31:0] counter_one_value,
  // results
  output logic [31:0] counter_two_value,
  output logic signed [31:0] counter_two_speed,
  output logic signed [31:0] counter_one_speed,
  // supervision and interrupt
  output logic enc_one_alarm,
  output logic enc_one_fault,
  output logic enc_two_alarm,
  output logic enc_two_fault,
  output logic irq
);
  import encoder_fast_counter_two_pkg::*;

  function automatic logic pair_lost(input enc_inputs_t e);
    return (e.channel_a == e.channel_a_n) | (e.channel_b == e.channel_b_n) |
           (e.index == e.index_n);
  endfunction

  function automatic logic [15:0] eff_period(input logic [15:0] p);
    return (p == 16'h0000) ? 16'h0001 : p;
  endfunction

  logic [15:0] counter_one_speed_period, counter_two_speed_period;
  logic [15:0] counter_two_preset_low, counter_two_preset_high;
  logic [15:0] counter_two_pulses_per_rev, counter_two_speed_filter_hz;
  logic [15:0] index_capture_result_low, index_capture_result_high;
  logic [1:0] input_one_signal_error_enable, input_two_signal_error_enable;
  count_mode_t counter_two_count_mode;
  logic [2:0] counter_two_index_action;
  logic counter_two_preset_load;
  logic [IRQ_BITS-1:0] irq_status, irq_mask, irq_events;

  logic load_prev, index_prev, step_up, step_down, tick, one_end, two_end, wr_hit;
  logic load_edge, index_rise, index_fall, index_event, cap_two, cap_one, do_clear;
  logic [15:0] rev_fraction, rev_count, one_period_cnt, two_period_cnt;
  logic [31:0] tick_cnt, one_last_pos, two_last_pos;
  logic signed [31:0] two_raw_speed;
  logic [15:0] loss_cnt [2];
  logic [1:0] loss_now, loss_prev, loss_level;

  assign wr_hit = reg_wr;
  assign load_edge = counter_two_preset_load & ~load_prev;
  assign index_rise = enc_two_in.index & ~index_prev;
  assign index_fall = ~enc_two_in.index & index_prev;
  assign do_clear = (counter_two_index_action == IDX_CLEAR) & index_rise;
  assign cap_two = ((counter_two_index_action == IDX_CAP_TWO_RISE) & index_rise) |
                   ((counter_two_index_action == IDX_CAP_TWO_FALL) & index_fall);
  assign cap_one = ((counter_two_index_action == IDX_CAP_ONE_RISE) & index_rise) |
                   ((counter_two_index_action == IDX_CAP_ONE_FALL) & index_fall);
  assign index_event = do_clear | cap_two | cap_one;
  assign one_end = tick & (one_period_cnt >= eff_period(counter_one_speed_period) - 16'h0001);
  assign two_end = tick & (two_period_cnt >= eff_period(counter_two_speed_period) - 16'h0001);

  step_decoder u_step_decoder (
    .core_clk (core_clk),
    .resetn (resetn),
    .mode (counter_two_count_mode),
    .chan_a (enc_two_in.channel_a),
    .chan_b (enc_two_in.channel_b),
    .step_up (step_up),
    .step_down (step_down)
  );

  speed_lowpass u_speed_lowpass (
    .core_clk (core_clk),
    .resetn (resetn),
    .sample (tick),
    .raw (two_raw_speed),
    .cutoff_hz (counter_two_speed_filter_hz),
    .filtered (counter_two_speed)
  );

  // software writes
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      counter_one_speed_period <= RST_SPEED_PERIOD;
      input_one_signal_error_enable <= 2'h0;
      counter_two_count_mode <= MODE_OFF;
      counter_two_index_action <= 3'h0;
      counter_two_preset_load <= 1'b0;
      counter_two_preset_low <= 16'h0000;
      counter_two_preset_high <= 16'h0000;
      counter_two_pulses_per_rev <= RST_PULSES_PER_REV;
      counter_two_speed_filter_hz <= RST_SPEED_FILTER_HZ;
      counter_two_speed_period <= RST_SPEED_PERIOD;
      input_two_signal_error_enable <= 2'h0;
      irq_mask <= '0;
    end
    else if (wr_hit)
    begin
      case (reg_addr)
        OFS_ONE_SPEED_PERIOD: counter_one_speed_period <= reg_wdata;
        OFS_ONE_ERROR_ENABLE: input_one_signal_error_enable <= reg_wdata[1:0];
        OFS_COUNT_MODE: counter_two_count_mode <= count_mode_t'(reg_wdata[1:0]);
        OFS_INDEX_ACTION: counter_two_index_action <= reg_wdata[2:0];
        OFS_PRESET_LOAD: counter_two_preset_load <= reg_wdata[0];
        OFS_PRESET_LOW: counter_two_preset_low <= reg_wdata;
        OFS_PRESET_HIGH: counter_two_preset_high <= reg_wdata;
        OFS_PULSES_PER_REV: counter_two_pulses_per_rev <= reg_wdata;
        OFS_SPEED_FILTER_HZ: counter_two_speed_filter_hz <= reg_wdata;
        OFS_TWO_SPEED_PERIOD: counter_two_speed_period <= reg_wdata;
        OFS_TWO_ERROR_ENABLE: input_two_signal_error_enable <= reg_wdata[1:0];
        OFS_IRQ_MASK: irq_mask <= reg_wdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // edge history of the load bit and the index
  always_ff @(posedge core_clk)
  begin
    load_prev <= resetn & counter_two_preset_load;
    index_prev <= resetn & enc_two_in.index;
  end

  // counter two: load beats index clear beats counting
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      counter_two_value <= 32'h00000000;
    else if (load_edge)
      counter_two_value <= {counter_two_preset_high, counter_two_preset_low};
    else if (do_clear)
      counter_two_value <= 32'h00000000;
    else if (step_up)
      counter_two_value <= counter_two_value + 32'h00000001;
    else if (step_down)
      counter_two_value <= counter_two_value - 32'h00000001;
  end

  // revolution scaling restarts whenever the count jumps
  always_ff @(posedge core_clk)
  begin
    if (!resetn || load_edge || do_clear)
    begin
      rev_fraction <= 16'h0000;
      rev_count <= 16'h0000;
    end
    else if (step_up)
    begin
      if (rev_fraction + 16'h0001 >= counter_two_pulses_per_rev)
      begin
        rev_fraction <= 16'h0000;
        rev_count <= rev_count + 16'h0001;
      end
      else
        rev_fraction <= rev_fraction + 16'h0001;
    end
    else if (step_down)
    begin
      if (rev_fraction == 16'h0000)
      begin
        rev_fraction <= (counter_two_pulses_per_rev == 16'h0000) ? 16'h0000 :
                        counter_two_pulses_per_rev - 16'h0001;
        rev_count <= rev_count - 16'h0001;
      end
      else
        rev_fraction <= rev_fraction - 16'h0001;
    end
  end

  // index capture
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      index_capture_result_low <= 16'h0000;
      index_capture_result_high <= 16'h0000;
    end
    else if (cap_two)
    begin
      index_capture_result_low <= counter_two_value[15:0];
      index_capture_result_high <= counter_two_value[31:16];
    end
    else if (cap_one)
    begin
      index_capture_result_low <= counter_one_value[15:0];
      index_capture_result_high <= counter_one_value[31:16];
    end
  end

  // 0.1 ms tick
  always_ff @(posedge core_clk)
  begin
    if (!resetn || tick_cnt >= 32'(TICK_LEN - 1))
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
    tick <= resetn && (tick_cnt >= 32'(TICK_LEN - 1));
  end

  // speed windows; a shortened period takes effect at the next tick
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      one_period_cnt <= 16'h0000;
      one_last_pos <= 32'h00000000;
      counter_one_speed <= 32'sh00000000;
    end
    else if (one_end)
    begin
      one_period_cnt <= 16'h0000;
      one_last_pos <= counter_one_value;
      counter_one_speed <= $signed(counter_one_value - one_last_pos);
    end
    else if (tick)
      one_period_cnt <= one_period_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      two_period_cnt <= 16'h0000;
      two_last_pos <= 32'h00000000;
      two_raw_speed <= 32'sh00000000;
    end
    else if (two_end)
    begin
      two_period_cnt <= 16'h0000;
      two_last_pos <= counter_two_value;
      two_raw_speed <= $signed(counter_two_value - two_last_pos);
    end
    else if (tick)
      two_period_cnt <= two_period_cnt + 16'h0001;
  end

  // loss must persist for a while so that edge skew does not trip it
  assign loss_now = {pair_lost(enc_two_in), pair_lost(enc_one_in)};

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      loss_cnt <= '{16'h0000, 16'h0000};
      {loss_level, loss_prev} <= 4'h0;
    end
    else
    begin
      loss_prev <= loss_level;
      for (int i = 0; i < 2; i++)
      begin
        if (!loss_now[i])
        begin
          loss_cnt[i] <= 16'h0000;
          loss_level[i] <= 1'b0;
        end
        else if (loss_cnt[i] >= 16'(LOSS_CYCLES - 1))
          loss_level[i] <= 1'b1;
        else
          loss_cnt[i] <= loss_cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    enc_one_alarm <= resetn & loss_level[0] &
                     (input_one_signal_error_enable == ERR_ALARM);
    enc_one_fault <= resetn & loss_level[0] &
                     (input_one_signal_error_enable == ERR_FAULT);
    enc_two_alarm <= resetn & loss_level[1] &
                     (input_two_signal_error_enable == ERR_ALARM);
    enc_two_fault <= resetn & loss_level[1] &
                     (input_two_signal_error_enable == ERR_FAULT);
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_comb
  begin
    irq_events = '0;
    irq_events[IRQ_INDEX] = index_event;
    irq_events[IRQ_PRESET] = load_edge;
    irq_events[IRQ_ONE_LOSS] = loss_level[0] & ~loss_prev[0] &
                               (input_one_signal_error_enable != ERR_OFF);
    irq_events[IRQ_TWO_LOSS] = loss_level[1] & ~loss_prev[1] &
                               (input_two_signal_error_enable != ERR_OFF);
    irq_events[IRQ_SPEED] = two_end;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      irq_status <= '0;
    else if (wr_hit && reg_addr == OFS_IRQ_STATUS)
      irq_status <= (irq_status & ~reg_wdata[IRQ_BITS-1:0]) | irq_events;
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge core_clk)
    irq <= resetn && (|(irq_status & irq_mask));

  // read data the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (!resetn || !reg_rd)
      reg_rdata <= 16'h0000;
    else
    begin
      case (reg_addr)
        OFS_ONE_SPEED_PERIOD: reg_rdata <= counter_one_speed_period;
        OFS_ONE_ERROR_ENABLE: reg_rdata <= {14'h0000, input_one_signal_error_enable};
        OFS_COUNT_MODE: reg_rdata <= {14'h0000, counter_two_count_mode};
        OFS_INDEX_ACTION: reg_rdata <= {13'h0000, counter_two_index_action};
        OFS_PRESET_LOAD: reg_rdata <= {15'h0000, counter_two_preset_load};
        OFS_PRESET_LOW: reg_rdata <= counter_two_preset_low;
        OFS_PRESET_HIGH: reg_rdata <= counter_two_preset_high;
        OFS_PULSES_PER_REV: reg_rdata <= counter_two_pulses_per_rev;
        OFS_SPEED_FILTER_HZ: reg_rdata <= counter_two_speed_filter_hz;
        OFS_TWO_SPEED_PERIOD: reg_rdata <= counter_two_speed_period;
        OFS_TWO_ERROR_ENABLE: reg_rdata <= {14'h0000, input_two_signal_error_enable};
        OFS_CAPTURE_LOW: reg_rdata <= index_capture_result_low;
        OFS_CAPTURE_HIGH: reg_rdata <= index_capture_result_high;
        OFS_COUNT_LOW: reg_rdata <= counter_two_value[15:0];
        OFS_COUNT_HIGH: reg_rdata <= counter_two_value[31:16];
        OFS_REV_FRACTION: reg_rdata <= rev_fraction;
        OFS_REV_COUNT: reg_rdata <= rev_count;
        OFS_SPEED_LOW: reg_rdata <= counter_two_speed[15:0];
        OFS_SPEED_HIGH: reg_rdata <= counter_two_speed[31:16];
        OFS_IRQ_STATUS: reg_rdata <= {{(16-IRQ_BITS){1'b0}}, irq_status};
        OFS_IRQ_MASK: reg_rdata <= {{(16-IRQ_BITS){1'b0}}, irq_mask};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // encoder_fast_counter_two

// [dv/enc_model.sv]
`timescale 1ns/1ps
module enc_model
  import encoder_fast_counter_two_pkg::*;
(
  // clock
  input wire logic core_clk,
  // motion and faults
  input wire logic step,
  input wire logic dir,
  input wire logic index,
  input wire logic lose,
  // differential lines
  output encoder_fast_counter_two_pkg::enc_inputs_t lines
);
  logic [1:0] phase = 2'b00;
  logic a;
  // gray phase, a leads b when dir is high
  always_ff @(posedge core_clk)
    if (step)
    begin
      phase <= dir ? phase + 2'b01 : phase - 2'b01;
    end
  assign a = phase[1] ^ phase[0];
  // broken cable: both wires pulled up, pair no longer complementary
  assign lines = lose ? 6'h3f : {a, ~a, phase[1], ~phase[1], index, ~index};
endmodule // enc_model

// [dv/encoder_fast_counter_two_assertions.sv]
`timescale 1ns/1ps
module encoder_fast_counter_two_checker
  import encoder_fast_counter_two_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // encoder and results
  input encoder_fast_counter_two_pkg::enc_inputs_t enc_two_in,
  input wire logic [31:0] counter_two_value,
  input wire logic enc_one_alarm,
  input wire logic enc_one_fault,
  input wire logic enc_two_alarm,
  input wire logic enc_two_fault,
  input wire logic irq
);
  logic [15:0] lo, hi, mode, err2, bad;
  logic ld;
  logic pair_bad;
  assign pair_bad = (enc_two_in.channel_a == enc_two_in.channel_a_n)
    || (enc_two_in.channel_b == enc_two_in.channel_b_n) || (enc_two_in.index == enc_two_in.index_n);
  always_ff @(posedge core_clk)
    if (!resetn)
    begin
      {lo, hi, mode, err2, ld} <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_PRESET_LOW: lo <= reg_wdata;
        OFS_PRESET_HIGH: hi <= reg_wdata;
        OFS_COUNT_MODE: mode <= reg_wdata & 16'h0003;
        OFS_TWO_ERROR_ENABLE: err2 <= reg_wdata & 16'h0003;
        OFS_PRESET_LOAD: ld <= reg_wdata[0];
        default: ;
      endcase
    end
  // saturating run length of a broken pair
  always_ff @(posedge core_clk)
    if (!resetn || !pair_bad)
    begin
      bad <= '0;
    end
    else if (bad != 16'hffff)
    begin
      bad <= bad + 16'h0001;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  reset_quiet_a: assert property (disable iff (1'b0)
    !resetn |=> counter_two_value == '0 && !irq) else $error("outputs not quiet after reset");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  count_step_a: assert property ($changed(counter_two_value) |->
    (counter_two_value - $past(counter_two_value)) inside {32'h1, 32'hffffffff}
    || counter_two_value == '0 || counter_two_value == {hi, lo}) else $error("counter jumped");
  mode_off_a: assert property (mode == '0 && $past(mode, 3) == '0
    && $changed(counter_two_value) |-> counter_two_value == '0 || counter_two_value == {hi, lo})
    else $error("counted while disabled");
  preset_load_a: assert property (reg_wr && reg_addr == OFS_PRESET_LOAD
    && reg_wdata[0] && !ld |-> ##2 counter_two_value == {hi, lo}) else $error("preset not loaded");
  one_excl_a: assert property (!(enc_one_alarm && enc_one_fault))
    else $error("alarm and fault together");
  loss_two_a: assert property (bad == 16'd1006 && err2 == $past(err2, 8)
    && (err2 == 16'h1 || err2 == 16'h2) |-> enc_two_alarm == (err2 == 16'h1)
    && enc_two_fault == (err2 == 16'h2)) else $error("loss not reported");
  loss_late_a: assert property ($rose(enc_two_alarm) || $rose(enc_two_fault)
    |-> bad >= 16'd995 || $past(bad) >= 16'd995) else $error("loss reported early");
  cover property (reg_wr && reg_addr == OFS_PRESET_LOAD && reg_wdata[0] && !ld);
  cover property ($rose(enc_two_fault));
  cover property ($rose(irq));
endmodule // encoder_fast_counter_two_checker

bind encoder_fast_counter_two encoder_fast_counter_two_checker i_checker (
  .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_two_in(enc_two_in),
  .counter_two_value(counter_two_value), .enc_one_alarm(enc_one_alarm),
  .enc_one_fault(enc_one_fault), .enc_two_alarm(enc_two_alarm),
  .enc_two_fault(enc_two_fault), .irq(irq)
);

// [dv/tb_encoder_fast_counter_two.sv]
`timescale 1ns/1ps
module tb_encoder_fast_counter_two;
  import encoder_fast_counter_two_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, rv;
  enc_inputs_t one_in, two_in;
  logic [31:0] one_val = '0;
  logic [31:0] cnt, pre, v1;
  logic signed [31:0] spd_two, spd_one;
  logic al1, fl1, al2, fl2, irq;
  logic st = 1'b0;
  logic dr = 1'b1;
  logic ix = 1'b0;
  logic ls1 = 1'b0;
  logic ls2 = 1'b0;
  logic run1 = 1'b0;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'hfd6f020f;
  localparam logic [15:0] RST_TBL [13] = '{16'h000a, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0400, 16'h01f4, 16'h000a, 16'h0, 16'h0, 16'h0};
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (run1)
      one_val <= one_val + 32'd1;
  encoder_fast_counter_two #(.TICK_LEN(10)) i_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_one_in(one_in),
    .enc_two_in(two_in), .counter_one_value(one_val), .counter_two_value(cnt),
    .counter_two_speed(spd_two), .counter_one_speed(spd_one), .enc_one_alarm(al1),
    .enc_one_fault(fl1), .enc_two_alarm(al2), .enc_two_fault(fl2), .irq(irq));
  enc_model i_one (.core_clk(core_clk), .step(1'b0), .dir(1'b0), .index(1'b0), .lose(ls1),
    .lines(one_in));
  enc_model i_two (.core_clk(core_clk), .step(st), .dir(dr), .index(ix), .lose(ls2),
    .lines(two_in));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    rv = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic rck(input logic [4:0] a, input logic [15:0] e);
    rd(a);
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, rv});
  endtask
  // rising load edge needs the bit low first
  task automatic load(input logic [31:0] v);
    wr(OFS_PRESET_LOW, v[15:0]);
    wr(OFS_PRESET_HIGH, v[31:16]);
    wr(OFS_PRESET_LOAD, 16'h0);
    wr(OFS_PRESET_LOAD, 16'h1);
    @(posedge core_clk);
  endtask
  task automatic mv(input int n, input logic d);
    repeat (n)
    begin
      st <= 1'b1;
      dr <= d;
      @(posedge core_clk);
      st <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  // count change over one full forward gray cycle
  function automatic logic [31:0] quad(input int m);
    case (m)
      1: return 32'd4;
      2: return 32'hffffffff;
      default: return 32'd0;
    endcase
  endfunction
  // capture expected for each index action
  function automatic logic [31:0] cap_exp(input int a, input logic [31:0] p, v);
    case (a)
      2: return p;
      3: return p + 32'd1;
      4: return v;
      5: return v + 32'd1;
      default: return 32'd0;
    endcase
  endfunction
  initial
  begin
    #500_000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 13; i++)
      rck(5'(i), RST_TBL[i]);
    rck(5'h1f, 16'h0);
    rv = 16'($random(seed));
    wr(OFS_PULSES_PER_REV, rv);
    rck(OFS_PULSES_PER_REV, rv);
    wr(OFS_COUNT_MODE, 16'hffff);
    rck(OFS_COUNT_MODE, 16'h0003);
    $display("registers done");
    for (int m = 0; m < 4; m++)
    begin
      pre = $random(seed);
      wr(OFS_COUNT_MODE, 16'(m));
      load(pre);
      mv(4, 1'b1);
      chk("count", pre + quad(m), cnt);
    end
    wr(OFS_COUNT_MODE, 16'h1);
    mv(4, 1'b0);
    chk("reverse", pre - 32'd4, cnt);
    load(32'hffffffff);
    mv(1, 1'b1);
    chk("wrap up", 32'h0, cnt);
    wr(OFS_PRESET_LOAD, 16'h1);
    wr(OFS_PRESET_LOAD, 16'h0);
    @(posedge core_clk);
    chk("no reload", 32'h0, cnt);
    mv(1, 1'b0);
    chk("wrap down", 32'hffffffff, cnt);
    chk("irq masked", 32'h0, irq);
    wr(OFS_IRQ_MASK, 16'h0002);
    @(posedge core_clk);
    chk("irq", 32'h1, irq);
    wr(OFS_IRQ_STATUS, 16'h0002);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, irq);
    $display("counting done");
    for (int a = 0; a < 6; a++)
    begin
      pre = $random(seed);
      load(pre);
      wr(OFS_INDEX_ACTION, 16'(a));
      v1 = one_val;
      ix <= 1'b1;
      repeat (4) @(posedge core_clk);
      run1 <= 1'b1;
      @(posedge core_clk);
      run1 <= 1'b0;
      mv(1, 1'b1);
      ix <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk("index count", a == 1 ? 32'h1 : pre + 32'h1, cnt);
      rd(OFS_CAPTURE_HIGH);
      chk("capture high", cap_exp(a, pre, v1) >> 16, {16'h0, rv});
      rck(OFS_CAPTURE_LOW, 16'(cap_exp(a, pre, v1)));
    end
    $display("index done");
    wr(OFS_TWO_SPEED_PERIOD, 16'h0002);
    wr(OFS_SPEED_FILTER_HZ, 16'd4000);
    run1 <= 1'b1;
    fork
      mv(60, 1'b1);
      begin
        repeat (220) @(posedge core_clk);
        chk("speed two", 32'd5, spd_two);
        chk("speed one", 32'd100, spd_one);
      end
    join
    run1 <= 1'b0;
    $display("speed done");
    wr(OFS_INDEX_ACTION, 16'h0);
    wr(OFS_ONE_ERROR_ENABLE, 16'h1);
    wr(OFS_TWO_ERROR_ENABLE, 16'h2);
    ls1 <= 1'b1;
    ls2 <= 1'b1;
    repeat (1010) @(posedge core_clk);
    chk("loss flags", 32'h9, {al1, fl1, al2, fl2});
    ls1 <= 1'b0;
    ls2 <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("loss cleared", 32'h0, {al1, fl1, al2, fl2});
    $display("loss done");
    complete_run();
  end
endmodule // tb_encoder_fast_counter_two
